// >>> hdl/uepic_top.sv
// Purpose: endpoint fifo reset controls and endpoint interrupt aggregation
// Assumes: sfr bus on the same clock, single-cycle read and write strobes
// Notes: read data and request are registered
`timescale 1ns/1ps
`default_nettype none
module uepic_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // special function register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [uepic_pkg::SFR_W-1:0] i_sfr_wdata,
  output logic [uepic_pkg::SFR_W-1:0] o_sfr_rdata,
  // per-endpoint status sources, endpoint n at [n]
  input wire logic [uepic_pkg::NUM_EP-1:0] i_transmit_complete,
  input wire logic [uepic_pkg::NUM_EP-1:0] i_out_received_bank0,
  input wire logic [uepic_pkg::NUM_EP-1:0] i_out_received_bank1,
  input wire logic [uepic_pkg::NUM_EP-1:0] i_setup_received,
  input wire logic [uepic_pkg::NUM_EP-1:0] i_stall_sent_or_crc_error,
  // fifo reset levels and usb interrupt request
  output logic [uepic_pkg::NUM_EP-1:0] o_endpoint_fifo_reset,
  output logic o_usb_irq
);
  import uepic_pkg::*;

  // ----------------------------------------------------------------
  // registers and internal signals
  // ----------------------------------------------------------------
  logic [NUM_EP-1:0] fifo_reset_reg; // software fifo reset bits
  logic [NUM_EP-1:0] enables_reg; // interrupt enables
  logic [NUM_EP-1:0] flags; // per-endpoint flags
  logic [NUM_EP-1:0] reqs; // gated flags
  logic [SFR_W-1:0] rdata_next; // read mux

  // fifo reset register, only bits 6..0 stored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifo_reset_reg <= RST_FIFO_RESET;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_FIFO_RESET) begin
      fifo_reset_reg <= i_sfr_wdata[NUM_EP-1:0];
    end
  end

  // fifo held in reset for as long as its bit is set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_endpoint_fifo_reset <= RST_FIFO_RESET;
    end else begin
      o_endpoint_fifo_reset <= fifo_reset_reg;
    end
  end

  // interrupt enable register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enables_reg <= RST_INT_ENABLES;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_INT_ENABLES) begin
      enables_reg <= i_sfr_wdata[NUM_EP-1:0];
    end
  end

  // ----------------------------------------------------------------
  // per-endpoint flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      logic [NUM_SRC-1:0] src; // this endpoint's sources
      // gather the five status sources
      always_comb begin
        src = '0;
        src[SRC_TX_COMPLETE] = i_transmit_complete[g];
        src[SRC_OUT_BANK0] = i_out_received_bank0[g];
        src[SRC_OUT_BANK1] = i_out_received_bank1[g];
        src[SRC_SETUP] = i_setup_received[g];
        src[SRC_STALL_CRC] = i_stall_sent_or_crc_error[g];
      end
      uepic_ep_flag u_flag (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(src),
        .i_enable(enables_reg[g]),
        .o_flag(flags[g]),
        .o_req(reqs[g])
      );
    end
  endgenerate

  // usb interrupt request, registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_usb_irq <= 1'h0;
    end else begin
      o_usb_irq <= |reqs;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // flag register has no write path; bit 7 always zero
  always_comb begin
    rdata_next = '0;
    case (i_sfr_addr)
      ADDR_INT_FLAGS: rdata_next = {1'h0, flags};
      ADDR_FIFO_RESET: rdata_next = {1'h0, fifo_reset_reg};
      ADDR_INT_ENABLES: rdata_next = {1'h0, enables_reg};
      default: rdata_next = '0;
    endcase
  end

  // registered read data, updated on read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= '0;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // a write strobe aimed at the fifo reset register
  sequence s_fifo_wr;
    i_sfr_wr && i_sfr_addr == ADDR_FIFO_RESET;
  endsequence
  // a cycle with no write to the fifo reset register
  sequence s_fifo_quiet;
    !(i_sfr_wr && i_sfr_addr == ADDR_FIFO_RESET);
  endsequence
  // a write strobe aimed at the enable register
  sequence s_en_wr;
    i_sfr_wr && i_sfr_addr == ADDR_INT_ENABLES;
  endsequence
  // a cycle with no write to the enable register
  sequence s_en_quiet;
    !(i_sfr_wr && i_sfr_addr == ADDR_INT_ENABLES);
  endsequence
  // a read strobe aimed at the flag register
  sequence s_flag_rd;
    i_sfr_rd && i_sfr_addr == ADDR_INT_FLAGS;
  endsequence

  // reserved bit never reads as one
  a_reserved_zero: assert property (
    @(posedge i_clk) disable iff (i_rst) !o_sfr_rdata[SFR_W-1])
    else $error("reserved bit read as one");
  // a fifo reset write reaches the outputs two edges later
  a_fifo_held: assert property (
    @(posedge i_clk) disable iff (i_rst) s_fifo_wr |-> ##2
    o_endpoint_fifo_reset == $past(i_sfr_wdata[NUM_EP-1:0], 2))
    else $error("fifo reset did not follow write");
  // outputs hold once no write is left in the pipe
  a_fifo_steady: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_fifo_quiet ##1 s_fifo_quiet |=> $stable(o_endpoint_fifo_reset))
    else $error("fifo reset released without write");
  // the stored reset bits move only on a write
  a_fifo_reg_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_fifo_quiet |=> $stable(fifo_reset_reg))
    else $error("fifo reset bits changed without write");
  // a flag read returns the flags seen at the read edge
  a_flags_ro: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_flag_rd |=> o_sfr_rdata[NUM_EP-1:0] == $past(flags))
    else $error("flag read mismatch");
  // read data holds between read strobes
  a_rdata_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without read");
  // setup source of endpoint 0 sets its flag
  a_src_to_flag: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_setup_received[0] |=> flags[0])
    else $error("setup source missed");
  // every flag is the or of its five sources one edge earlier
  a_flag_map: assert property (
    @(posedge i_clk) disable iff (i_rst)
    1'h1 |=> flags == $past(i_transmit_complete | i_out_received_bank0 |
    i_out_received_bank1 | i_setup_received | i_stall_sent_or_crc_error))
    else $error("flag does not match its sources");
  // an enabled flag raises the request
  a_irq_gated: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (|(flags & enables_reg)) |=> o_usb_irq)
    else $error("request not raised");
  // no enabled flag, no request
  a_irq_quiet: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !(|(flags & enables_reg)) |=> !o_usb_irq)
    else $error("request with nothing enabled");
  // an enable write lands in the register
  a_enable_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_en_wr |=> enables_reg == $past(i_sfr_wdata[NUM_EP-1:0]))
    else $error("enable write lost");
  // enables move only on a write
  a_enable_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_en_quiet |=> $stable(enables_reg))
    else $error("enables changed without write");
  // endpoint 1 flag drops once its sources are clear
  a_flag_hw_clear: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (flags[1] && !(i_transmit_complete[1] | i_out_received_bank0[1] |
    i_out_received_bank1[1] | i_setup_received[1] |
    i_stall_sent_or_crc_error[1])) |=> !flags[1])
    else $error("flag not cleared by hardware");
  // transmit source of endpoint 6 sets its flag
  a_flag_set: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_transmit_complete[6] |=> flags[6])
    else $error("endpoint 6 flag missed");
endmodule
`default_nettype wire

// >>> hdl/uepic_pkg.sv
// Purpose: constants for the endpoint interrupt and fifo reset block
// Assumes: 8-bit special function register access, addresses in sfr space
// Notes: one bit per endpoint, endpoints 0 to 6
package uepic_pkg;
  // number of endpoints and sfr width
  localparam int NUM_EP = 7;
  localparam int SFR_W = 8;
  // sfr addresses
  localparam logic [7:0] ADDR_INT_FLAGS = 8'hf8;
  localparam logic [7:0] ADDR_FIFO_RESET = 8'hd5;
  localparam logic [7:0] ADDR_INT_ENABLES = 8'hc2;
  // reset values
  localparam logic [6:0] RST_FIFO_RESET = 7'h00;
  localparam logic [6:0] RST_INT_ENABLES = 7'h00;
  // status source layout, five sources per endpoint
  localparam int NUM_SRC = 5;
  localparam int SRC_TX_COMPLETE = 0;
  localparam int SRC_OUT_BANK0 = 1;
  localparam int SRC_OUT_BANK1 = 2;
  localparam int SRC_SETUP = 3;
  localparam int SRC_STALL_CRC = 4;
endpackage

// >>> hdl/uepic_ep_flag.sv
// Purpose: one endpoint's interrupt flag and its gated request term
// Assumes: source bits come from logic on the same clock
// Notes: flag follows the or of its sources, one cycle late
`timescale 1ns/1ps
`default_nettype none
module uepic_ep_flag (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // status sources and enable
  input wire logic [uepic_pkg::NUM_SRC-1:0] i_src,
  input wire logic i_enable,
  // flag and gated request
  output logic o_flag,
  output logic o_req
);
  import uepic_pkg::*;

  // flag set by any source, cleared only when all sources are clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'h0;
    end else begin
      o_flag <= |i_src;
    end
  end

  // request term is flag gated by enable
  assign o_req = o_flag & i_enable;

  // any live source sets the flag at the next edge
  a_flag_follows: assert property (
    @(posedge i_clk) disable iff (i_rst) (|i_src) |=> o_flag)
    else $error("flag did not set after a source");
  // with every source clear the flag drops at the next edge
  a_flag_clears: assert property (
    @(posedge i_clk) disable iff (i_rst) !(|i_src) |=> !o_flag)
    else $error("flag stayed set with no source");
endmodule
`default_nettype wire

// >>> test/uepic_top_tb.sv
// Purpose: self-checking bench for the endpoint irq and fifo reset block
// Assumes: sfr strobes driven at the falling edge, one cycle wide
// Notes: expected values are literals in the bench; addresses, counts and source indices come from the package
`timescale 1ns/1ps
`default_nettype none
module uepic_top_tb;
  import uepic_pkg::*;
  // --------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [6:0] src [NUM_SRC] = '{default: 7'h00};
  logic [6:0] fifo_rst;
  logic irq;
  int err_total = 0;
  int checks = 0;
  // 100 mhz clock
  always #5 i_clk = ~i_clk;
  uepic_top dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_transmit_complete(src[SRC_TX_COMPLETE]),
    .i_out_received_bank0(src[SRC_OUT_BANK0]),
    .i_out_received_bank1(src[SRC_OUT_BANK1]),
    .i_setup_received(src[SRC_SETUP]),
    .i_stall_sent_or_crc_error(src[SRC_STALL_CRC]),
    .o_endpoint_fifo_reset(fifo_rst), .o_usb_irq(irq)
  );
  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  // compare one byte, count and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // write strobe, then wait until the fifo reset output has moved
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge i_clk);
    wr = 1'h0;
    repeat (2) @(negedge i_clk);
  endtask
  // read strobe, then compare the held read data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    addr = a;
    rd = 1'h1;
    @(negedge i_clk);
    rd = 1'h0;
    @(negedge i_clk);
    chk(rdata, exp);
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  // values after reset, unmapped read gives zero, flags not writable
  task automatic t_reset();
    chk({1'h0, fifo_rst}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd_chk(ADDR_FIFO_RESET, 8'h00);
    rd_chk(ADDR_INT_FLAGS, 8'h00);
    rd_chk(ADDR_INT_ENABLES, 8'h00);
    rd_chk(8'h00, 8'h00);
    sfr_wr(ADDR_INT_FLAGS, 8'h7f);
    rd_chk(ADDR_INT_FLAGS, 8'h00);
  endtask
  // reset every fifo first, then walk each bit; bit 7 never written
  task automatic t_fifo();
    sfr_wr(ADDR_FIFO_RESET, 8'h7f);
    chk({1'h0, fifo_rst}, 8'h7f);
    for (int n = 0; n < NUM_EP; n++) begin
      sfr_wr(ADDR_FIFO_RESET, 8'h01 << n);
      chk({1'h0, fifo_rst}, 8'h01 << n);
      rd_chk(ADDR_FIFO_RESET, 8'h01 << n);
      chk({1'h0, fifo_rst}, 8'h01 << n);
    end
    sfr_wr(ADDR_FIFO_RESET, 8'h00);
    chk({1'h0, fifo_rst}, 8'h00);
    sfr_wr(ADDR_INT_ENABLES, 8'h7f);
    rd_chk(ADDR_INT_ENABLES, 8'h7f);
  endtask
  // every source of every endpoint, gated by its enable
  task automatic t_flags();
    for (int n = 0; n < NUM_EP; n++) begin
      for (int k = 0; k < NUM_SRC; k++) begin
        sfr_wr(ADDR_INT_ENABLES, 8'h00);
        src[k][n] = 1'h1;
        rd_chk(ADDR_INT_FLAGS, 8'h01 << n);
        chk({7'h00, irq}, 8'h00);
        sfr_wr(ADDR_INT_ENABLES, 8'h01 << n);
        chk({7'h00, irq}, 8'h01);
        sfr_wr(ADDR_INT_ENABLES, ~(8'h01 << n) & 8'h7f);
        chk({7'h00, irq}, 8'h00);
        sfr_wr(ADDR_INT_FLAGS, 8'h7f);
        rd_chk(ADDR_INT_FLAGS, 8'h01 << n);
        src[k][n] = 1'h0;
        rd_chk(ADDR_INT_FLAGS, 8'h00);
      end
    end
  endtask
  // flag stays while one of two sources remains
  task automatic t_multi();
    sfr_wr(ADDR_INT_ENABLES, 8'h40);
    src[SRC_TX_COMPLETE][6] = 1'h1;
    src[SRC_STALL_CRC][6] = 1'h1;
    sfr_wr(ADDR_INT_FLAGS, 8'h00);
    src[SRC_TX_COMPLETE][6] = 1'h0;
    rd_chk(ADDR_INT_FLAGS, 8'h40);
    chk({7'h00, irq}, 8'h01);
    src[SRC_STALL_CRC][6] = 1'h0;
    rd_chk(ADDR_INT_FLAGS, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  // reset in mid-run clears every register and output
  task automatic t_midreset();
    sfr_wr(ADDR_FIFO_RESET, 8'h7f);
    sfr_wr(ADDR_INT_ENABLES, 8'h01);
    src[SRC_SETUP][0] = 1'h1;
    repeat (2) @(negedge i_clk);
    chk({7'h00, irq}, 8'h01);
    chk({1'h0, fifo_rst}, 8'h7f);
    i_rst = 1'h1;
    src[SRC_SETUP][0] = 1'h0;
    repeat (2) @(negedge i_clk);
    chk({1'h0, fifo_rst}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    i_rst = 1'h0;
    rd_chk(ADDR_INT_ENABLES, 8'h00);
    rd_chk(ADDR_FIFO_RESET, 8'h00);
    rd_chk(ADDR_INT_FLAGS, 8'h00);
  endtask
  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'h0;
    t_reset();
    t_fifo();
    t_flags();
    t_multi();
    t_midreset();
    close_out();
  end
  // cut a hang short, far beyond the expected run
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
